// >>> hw/cpimg_defines.svh
// Field positions, fixed values and per-model values of the parameter image
`ifndef CPIMG_DEFINES_SVH
`define CPIMG_DEFINES_SVH

`define CPIMG_LAYOUT_HI 127
`define CPIMG_LAYOUT_LO 126
`define CPIMG_SPEC_HI 125
`define CPIMG_SPEC_LO 122
`define CPIMG_ACCT_HI 119
`define CPIMG_ACCT_LO 112
`define CPIMG_NCLK_HI 111
`define CPIMG_NCLK_LO 104
`define CPIMG_RATE_HI 103
`define CPIMG_RATE_LO 96
`define CPIMG_CLASS_HI 95
`define CPIMG_CLASS_LO 84
`define CPIMG_RBL_HI 83
`define CPIMG_RBL_LO 80
`define CPIMG_PARTIAL_BIT 79
`define CPIMG_WMIS_BIT 78
`define CPIMG_RMIS_BIT 77
`define CPIMG_DSR_BIT 76
`define CPIMG_SIZE_HI 73
`define CPIMG_SIZE_LO 62
`define CPIMG_RCMIN_HI 61
`define CPIMG_RCMIN_LO 59
`define CPIMG_RCMAX_HI 58
`define CPIMG_RCMAX_LO 56
`define CPIMG_WCMIN_HI 55
`define CPIMG_WCMIN_LO 53
`define CPIMG_WCMAX_HI 52
`define CPIMG_WCMAX_LO 50
`define CPIMG_SIZE_FACTOR_HI 49
`define CPIMG_SIZE_FACTOR_LO 47

`define CPIMG_LAYOUT_VAL 2'h2
`define CPIMG_SPEC_VAL 4'h3
`define CPIMG_ACCT_VAL 8'h26
`define CPIMG_NCLK_VAL 8'h01
`define CPIMG_RATE_VAL 8'h2A
`define CPIMG_CLASS_VAL 12'h0F5
`define CPIMG_RBL_VAL 4'h9
`define CPIMG_FLAG_OFF 1'h0
`define CPIMG_SIZE_32M 12'h7A7
`define CPIMG_SIZE_BIG 12'hF4F
`define CPIMG_SIZE_FACTOR_64M 3'h3
`define CPIMG_SIZE_FACTOR_128M 3'h4
`define CPIMG_CURR_DEF 3'h2
`define CPIMG_EXP_MAX 3'h3
`define CPIMG_SIZE_FACTOR_LIMIT 4'h8
`define CPIMG_RBL_LIMIT 4'hC
`define CPIMG_NCLK_UNIT 16'h0064
`define CPIMG_BIT0_VAL 1'h1

`endif

// >>> hw/cpimg_pkg.sv
// Types shared by both ends of the parameter image link
package cpimg_pkg;
  typedef enum logic [1:0] {
    CPIMG_MODEL_32M = 2'h0,
    CPIMG_MODEL_64M = 2'h1,
    CPIMG_MODEL_128M = 2'h2
  } cpimg_model_t;

  typedef enum logic [2:0] {
    CPIMG_IDLE = 3'h1,
    CPIMG_WAIT = 3'h2,
    CPIMG_EVAL = 3'h4
  } cpimg_state_t;
endpackage : cpimg_pkg

// >>> hw/cpimg_if.sv
// Link between the card image and the host that reads it
interface cpimg_if;
  logic rd_req;
  logic rd_valid;
  logic [127:0] image;

  modport card (input rd_req, output rd_valid, output image);
  modport host (output rd_req, input rd_valid, input image);
endinterface : cpimg_if

// >>> hw/cpimg_rom.sv
// Constant image builder, selected by model
`include "cpimg_defines.svh"
module cpimg_rom
  import cpimg_pkg::*;
#(
  parameter cpimg_model_t MODEL = CPIMG_MODEL_32M
) (
  output logic [127:0] image
);
  logic [11:0] size_code;
  logic [2:0] size_factor_code;

  always_comb begin
    case (MODEL)
      CPIMG_MODEL_64M: begin
        size_code = `CPIMG_SIZE_BIG;
        size_factor_code = `CPIMG_SIZE_FACTOR_64M;
      end
      CPIMG_MODEL_128M: begin
        size_code = `CPIMG_SIZE_BIG;
        size_factor_code = `CPIMG_SIZE_FACTOR_128M;
      end
      default: begin
        size_code = `CPIMG_SIZE_32M;
        size_factor_code = `CPIMG_SIZE_FACTOR_64M;
      end
    endcase
  end

  always_comb begin
    image = 128'h0;
    image[`CPIMG_LAYOUT_HI:`CPIMG_LAYOUT_LO] = `CPIMG_LAYOUT_VAL;
    image[`CPIMG_SPEC_HI:`CPIMG_SPEC_LO] = `CPIMG_SPEC_VAL;
    image[`CPIMG_ACCT_HI:`CPIMG_ACCT_LO] = `CPIMG_ACCT_VAL;
    image[`CPIMG_NCLK_HI:`CPIMG_NCLK_LO] = `CPIMG_NCLK_VAL;
    image[`CPIMG_RATE_HI:`CPIMG_RATE_LO] = `CPIMG_RATE_VAL;
    image[`CPIMG_CLASS_HI:`CPIMG_CLASS_LO] = `CPIMG_CLASS_VAL;
    image[`CPIMG_RBL_HI:`CPIMG_RBL_LO] = `CPIMG_RBL_VAL;
    image[`CPIMG_PARTIAL_BIT] = `CPIMG_FLAG_OFF;
    image[`CPIMG_WMIS_BIT] = `CPIMG_FLAG_OFF;
    image[`CPIMG_RMIS_BIT] = `CPIMG_FLAG_OFF;
    image[`CPIMG_DSR_BIT] = `CPIMG_FLAG_OFF;
    image[`CPIMG_SIZE_HI:`CPIMG_SIZE_LO] = size_code;
    image[`CPIMG_RCMIN_HI:`CPIMG_RCMIN_LO] = `CPIMG_CURR_DEF;
    image[`CPIMG_WCMIN_HI:`CPIMG_WCMIN_LO] = `CPIMG_CURR_DEF;
    image[`CPIMG_RCMAX_HI:`CPIMG_RCMAX_LO] = `CPIMG_CURR_DEF;
    image[`CPIMG_WCMAX_HI:`CPIMG_WCMAX_LO] = `CPIMG_CURR_DEF;
    image[`CPIMG_SIZE_FACTOR_HI:`CPIMG_SIZE_FACTOR_LO] = size_factor_code;
    image[0] = `CPIMG_BIT0_VAL;
  end
endmodule : cpimg_rom

// >>> hw/cpimg_card.sv
// Card end: answers a read request with the fixed parameter image
`include "cpimg_defines.svh"
module cpimg_card
  import cpimg_pkg::*;
#(
  parameter cpimg_model_t MODEL = CPIMG_MODEL_32M
) (
  input wire logic core_clk,
  input wire logic arst_n,
  cpimg_if.card link
);
  logic [127:0] rom_image;

  cpimg_rom #(.MODEL(MODEL)) u_rom (
    .image(rom_image)
  );

  // ****************
  // Answer
  // ****************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link.rd_valid <= 1'h0;
    end else begin
      link.rd_valid <= link.rd_req;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link.image <= 128'h0;
    end else if (link.rd_req) begin
      link.image <= rom_image;
    end
  end
endmodule : cpimg_card

// >>> hw/cpimg_host.sv
// Host end: reads the image, decodes it and derives access figures
// Behaviour
// - Layout version field reads binary 10
// - Spec version field reads binary 0011
// - Access time: exponent 2:0, mantissa 6:3
// - Access time byte is 0x26, 1.5 ms
// - Clocked access counts 100-cycle units, 0x01
// - Host reports async and clocked latency as separate outputs
// - Rate byte: exponent 2:0, mantissa 6:3
// - Rate byte is 0x2A, 20 Mbit/s
// - Command class mask is 0x0F5
// - Block length two power code, 0x09
// - Partial reads only when flag set
// - Write boundary flag zero, no spanning
// - Read boundary flag zero, no crossing
// - No driver stage present
// - Capacity from size, multiplier, block length
// - Per-model size and multiplier values
// - Low-supply current codes 0 to 7
// - High-supply current codes 0 to 7
// - Other fields fixed
`include "cpimg_defines.svh"
module cpimg_host
  import cpimg_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  cpimg_if.host link,
  input wire logic start,
  output logic done,
  output logic image_ok,
  output logic [127:0] image,
  output logic [11:0] command_class_mask,
  output logic [11:0] block_length,
  output logic partial_read_allowed,
  output logic read_boundary_cross_flag,
  output logic write_boundary_cross_flag,
  output logic driver_stage_present,
  output logic [15:0] clocked_access_cycles,
  output logic [7:0] async_access_time,
  output logic [7:0] transfer_rate,
  output logic [2:0] read_current_low_supply,
  output logic [2:0] write_current_low_supply,
  output logic [2:0] read_current_high_supply,
  output logic [2:0] write_current_high_supply,
  output logic [31:0] capacity_bytes
);
  cpimg_state_t state;
  logic [127:0] img_q;
  logic [11:0] size_code;
  logic [2:0] size_factor_code;
  logic [3:0] rbl_code;
  logic [7:0] acct_b;
  logic [7:0] rate_b;
  logic next_ok;
  logic [31:0] next_capacity;

  assign size_code = img_q[`CPIMG_SIZE_HI:`CPIMG_SIZE_LO];
  assign size_factor_code = img_q[`CPIMG_SIZE_FACTOR_HI:`CPIMG_SIZE_FACTOR_LO];
  assign rbl_code = img_q[`CPIMG_RBL_HI:`CPIMG_RBL_LO];
  assign acct_b = img_q[`CPIMG_ACCT_HI:`CPIMG_ACCT_LO];
  assign rate_b = img_q[`CPIMG_RATE_HI:`CPIMG_RATE_LO];

  // ****************
  // Checks
  // ****************
  always_comb begin
    next_ok = 1'h1;
    if (img_q[`CPIMG_LAYOUT_HI:`CPIMG_LAYOUT_LO] != `CPIMG_LAYOUT_VAL)
      next_ok = 1'h0;
    if (img_q[`CPIMG_SPEC_HI:`CPIMG_SPEC_LO] != `CPIMG_SPEC_VAL)
      next_ok = 1'h0;
    if (acct_b[7] || acct_b[6:3] == 4'h0)
      next_ok = 1'h0;
    if (acct_b != `CPIMG_ACCT_VAL)
      next_ok = 1'h0;
    if (rate_b[7] || rate_b[6:3] == 4'h0 || rate_b[2:0] > `CPIMG_EXP_MAX)
      next_ok = 1'h0;
    if (rate_b != `CPIMG_RATE_VAL)
      next_ok = 1'h0;
    if (img_q[`CPIMG_CLASS_HI:`CPIMG_CLASS_LO] != `CPIMG_CLASS_VAL)
      next_ok = 1'h0;
    if (rbl_code >= `CPIMG_RBL_LIMIT)
      next_ok = 1'h0;
    if (img_q[`CPIMG_WMIS_BIT] != `CPIMG_FLAG_OFF)
      next_ok = 1'h0;
    if (img_q[`CPIMG_RMIS_BIT] != `CPIMG_FLAG_OFF)
      next_ok = 1'h0;
    if (img_q[`CPIMG_DSR_BIT] != `CPIMG_FLAG_OFF)
      next_ok = 1'h0;
    if ({1'h0, size_factor_code} >= `CPIMG_SIZE_FACTOR_LIMIT)
      next_ok = 1'h0;
  end

  // Capacity = (size + 1) * 2^(size_factor + 2) * 2^block length
  always_comb begin
    next_capacity = 32'({20'h0, size_code} + 32'h1) <<
      (5'(size_factor_code) + 5'h2 + 5'(rbl_code));
  end

  // ****************
  // Sequencer
  // ****************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= CPIMG_IDLE;
    end else begin
      case (state)
        CPIMG_IDLE: if (start) state <= CPIMG_WAIT;
        CPIMG_WAIT: if (link.rd_valid) state <= CPIMG_EVAL;
        CPIMG_EVAL: state <= CPIMG_IDLE;
        default: state <= CPIMG_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link.rd_req <= 1'h0;
    end else begin
      link.rd_req <= (state == CPIMG_IDLE) && start;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      img_q <= 128'h0;
    end else if (state == CPIMG_WAIT && link.rd_valid) begin
      img_q <= link.image;
    end
  end

  // ****************
  // Results
  // ****************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'h0;
    end else begin
      done <= (state == CPIMG_EVAL);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      image_ok <= 1'h0;
      image <= 128'h0;
      command_class_mask <= 12'h0;
      block_length <= 12'h0;
      partial_read_allowed <= 1'h0;
      read_boundary_cross_flag <= 1'h0;
      write_boundary_cross_flag <= 1'h0;
      driver_stage_present <= 1'h0;
      clocked_access_cycles <= 16'h0;
      async_access_time <= 8'h0;
      transfer_rate <= 8'h0;
      read_current_low_supply <= 3'h0;
      write_current_low_supply <= 3'h0;
      read_current_high_supply <= 3'h0;
      write_current_high_supply <= 3'h0;
      capacity_bytes <= 32'h0;
    end else if (state == CPIMG_EVAL) begin
      image_ok <= next_ok;
      image <= img_q;
      command_class_mask <= img_q[`CPIMG_CLASS_HI:`CPIMG_CLASS_LO];
      block_length <= 12'h1 << rbl_code;
      partial_read_allowed <= img_q[`CPIMG_PARTIAL_BIT];
      read_boundary_cross_flag <= img_q[`CPIMG_RMIS_BIT];
      write_boundary_cross_flag <= img_q[`CPIMG_WMIS_BIT];
      driver_stage_present <= img_q[`CPIMG_DSR_BIT];
      clocked_access_cycles <= 16'(img_q[`CPIMG_NCLK_HI:`CPIMG_NCLK_LO] *
        `CPIMG_NCLK_UNIT);
      async_access_time <= acct_b;
      transfer_rate <= rate_b;
      read_current_low_supply <=
        img_q[`CPIMG_RCMIN_HI:`CPIMG_RCMIN_LO];
      write_current_low_supply <=
        img_q[`CPIMG_WCMIN_HI:`CPIMG_WCMIN_LO];
      read_current_high_supply <=
        img_q[`CPIMG_RCMAX_HI:`CPIMG_RCMAX_LO];
      write_current_high_supply <=
        img_q[`CPIMG_WCMAX_HI:`CPIMG_WCMAX_LO];
      capacity_bytes <= next_capacity;
    end
  end
endmodule : cpimg_host

// >>> dv/cpimg_checker.sv
// Link checker for the parameter image read handshake and fixed fields
module cpimg_checker (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic [127:0] image
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ****************************************
  // Handshake
  // ****************************************
  chk_answer_follows: assert property (rd_req |=> rd_valid)
    else $error("request not answered next cycle");
  chk_no_spurious: assert property (!rd_req |=> !rd_valid)
    else $error("answer without request");
  chk_image_holds: assert property (rd_valid && !rd_req |=> $stable(image))
    else $error("image changed without request");

  // ****************************************
  // Fixed fields
  // ****************************************
  chk_layout_field: assert property (rd_valid |-> image[127:126] == 2'h2)
    else $error("layout field wrong");
  chk_spec_field: assert property (rd_valid |-> image[125:122] == 4'h3)
    else $error("spec version wrong");
  chk_access_byte: assert property (rd_valid |-> image[119:112] == 8'h26)
    else $error("access time byte wrong");
  chk_clocked_units: assert property (rd_valid |-> image[111:104] == 8'h01)
    else $error("clocked access byte wrong");
  chk_rate_byte: assert property (rd_valid |-> image[103:96] == 8'h2A)
    else $error("rate byte wrong");
  chk_class_mask: assert property (rd_valid |-> image[95:84] == 12'h0F5)
    else $error("class mask wrong");
  chk_block_flags: assert property (rd_valid |-> image[83:76] == 8'h90)
    else $error("block length or flags wrong");

  cover property (rd_req ##1 rd_valid);
  cover property (rd_valid && image[49:47] == 3'h3);
  cover property (!arst_n ##1 arst_n);
endmodule : cpimg_checker

// >>> dv/cpimg_bench.sv
// Both ends joined, user side of the host driven and judged
module cpimg_bench;
  import cpimg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic done, image_ok, partial_read_allowed, read_boundary_cross_flag;
  logic write_boundary_cross_flag, driver_stage_present;
  logic [127:0] image;
  logic [11:0] command_class_mask, block_length;
  logic [15:0] clocked_access_cycles;
  logic [7:0] async_access_time, transfer_rate;
  logic [2:0] read_current_low_supply, write_current_low_supply;
  logic [2:0] read_current_high_supply, write_current_high_supply;
  logic [31:0] capacity_bytes;
  int n_errors = 0;
  int checks = 0;

  cpimg_if lnk ();
  cpimg_card #(.MODEL(CPIMG_MODEL_64M)) cpimg_card_i (
    .core_clk, .arst_n, .link(lnk));
  cpimg_host cpimg_host_i (.core_clk, .arst_n, .link(lnk), .start, .done,
    .image_ok, .image, .command_class_mask, .block_length,
    .partial_read_allowed, .read_boundary_cross_flag,
    .write_boundary_cross_flag, .driver_stage_present,
    .clocked_access_cycles, .async_access_time, .transfer_rate,
    .read_current_low_supply, .write_current_low_supply,
    .read_current_high_supply, .write_current_high_supply, .capacity_bytes);
  cpimg_checker cpimg_checker_i (.core_clk, .arst_n, .rd_req(lnk.rd_req),
    .rd_valid(lnk.rd_valid), .image(lnk.image));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [127:0] seen,
                       input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_single_read();
    int n;
    @(posedge core_clk) start <= 1'b1;
    @(posedge core_clk) start <= 1'b0;
    for (n = 2; n < 12; n++) begin
      @(posedge core_clk);
      #1;
      if (done === 1'b1) break;
    end
    check("latency", n, 4);
    check("image_ok", image_ok, 1'b1);
    check("access", async_access_time, 8'h26);
    check("cycles", clocked_access_cycles, 16'h0064);
    check("rate", transfer_rate, 8'h2A);
    check("classes", command_class_mask, 12'h0F5);
    check("blk_len", block_length, 12'h200);
    check("partial", partial_read_allowed, 1'b0);
    check("wr_cross", write_boundary_cross_flag, 1'b0);
    check("rd_cross", read_boundary_cross_flag, 1'b0);
    check("driver", driver_stage_present, 1'b0);
    check("size", image[73:62], 12'hF4F);
    check("size_factor", image[49:47], 3'h3);
    check("capacity", capacity_bytes, 32'h03D40000);
    check("cur_rl", read_current_low_supply, 3'h2);
    check("cur_wl", write_current_low_supply, 3'h2);
    check("cur_rh", read_current_high_supply, 3'h2);
    check("cur_wh", write_current_high_supply, 3'h2);
    check("bit0", image[0], 1'b1);
    check("reserved", {image[121:120], image[75:74]}, 4'h0);
  endtask : t_single_read

  task automatic t_held_start();
    int cnt = 0;
    @(posedge core_clk) start <= 1'b1;
    for (int i = 1; i <= 14; i++) begin
      @(posedge core_clk);
      if (i == 5) start <= 1'b0;
      #1;
      if (done === 1'b1) cnt++;
    end
    check("done_count", cnt, 2);
  endtask : t_held_start

  task automatic t_mid_reset();
    @(posedge core_clk) start <= 1'b1;
    @(posedge core_clk) start <= 1'b0;
    @(posedge core_clk) arst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    check("rst_done", done, 1'b0);
    check("rst_ok", image_ok, 1'b0);
    check("rst_cap", capacity_bytes, 32'h0);
    check("rst_valid", lnk.rd_valid, 1'b0);
    @(posedge core_clk) arst_n <= 1'b1;
  endtask : t_mid_reset

  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    t_single_read();
    t_held_start();
    t_mid_reset();
    t_single_read();
    stop_test();
  end

  initial begin
    #5000;
    n_errors++;
    stop_test();
  end
endmodule : cpimg_bench
